// ---- src/iolm_status_image.sv ----
// Input image builder with its output FIFO
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module iolm_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    // Refused at elaboration: the pointer wrap bit needs a power-of-two depth
    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin
        $error("fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic push;
    logic pop;

    assign in_ready_o = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
    assign out_valid_o = wr_ptr != rd_ptr;
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge clock_i)
    begin
        if (push)
            mem[wr_ptr[AW-1:0]] <= in_data_i;
    end

    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module iolm_status_image
    import iolm_pkg::*;
#(
    parameter int NUM_PORTS = 4,
    parameter int PD_BYTES = 32,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // Cycle and configuration control
    input wire logic cycle_start_i,
    input wire logic reload_i,
    input wire logic [NUM_PORTS-1:0] cfg_used_i,
    input wire logic [NUM_PORTS-1:0][5:0] cfg_len_i,
    output logic busy_o,
    // Port-side state, same clock
    input wire iolm_pkg::iolm_port_s [NUM_PORTS-1:0] port_i,
    input wire logic [NUM_PORTS-1:0] event_i,
    input wire logic [NUM_PORTS-1:0] comm_lost_i,
    input wire logic event_ack_i,
    // Process data fetch, answered in the same cycle
    output logic [1:0] pd_port_o,
    output logic [4:0] pd_index_o,
    input wire logic [7:0] pd_data_i,
    // Image stream towards the input sync channel
    output logic img_valid_o,
    input wire logic img_ready_i,
    output iolm_pkg::iolm_img_s img_o,
    // Flags
    output logic event_flag_o,
    output logic comm_loss_flag_o
);
    import iolm_pkg::*;

    if (NUM_PORTS != NPORT || PD_BYTES != PD_MAX)
    begin
        $error("port count and data size are fixed by the image layout");
    end
    if (DEPTH != FIFO_DEPTH)
    begin
        $error("fifo depth must be 16");
    end

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_DIAG = 4'b0010,
        ST_STAT = 4'b0100,
        ST_PD = 4'b1000
    } iolm_state_e;

    iolm_state_e state;
    logic [NPORT-1:0][5:0] pd_len;
    logic [15:0] shot_diag;
    logic [NPORT-1:0][7:0] shot_stat;
    logic [5:0] byte_cnt;
    logic [2:0] port_sel;
    logic fifo_ready;
    logic push;
    iolm_img_s push_data;
    logic is_last;
    logic [2:0] first_pd;
    logic [2:0] after_pd;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration is only taken on reload, so a port edited mid-run
    // keeps its old image length until the next reload
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            pd_len <= {NPORT{CFG_LEN_RESET}};
        else if (reload_i)
        begin
            for (int p = 0; p < NPORT; p++)
            begin
                if (!cfg_used_i[p])
                    pd_len[p] <= '0;
                else if (cfg_len_i[p] > 6'(PD_MAX))
                    pd_len[p] <= 6'(PD_MAX);
                else
                    pd_len[p] <= cfg_len_i[p];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event flag holds until acknowledged; a new event beats the ack
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            event_flag_o <= 1'b0;
        else if (|event_i)
            event_flag_o <= 1'b1;
        else if (event_ack_i)
            event_flag_o <= 1'b0;
    end

    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            comm_loss_flag_o <= 1'b0;
        else
            comm_loss_flag_o <= |comm_lost_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Diagnostic and status snapshot taken once per cycle; process data bytes are fetched live while the image is built
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            shot_diag <= DIAG_RESET;
            shot_stat <= '0;
        end
        else if (state == ST_IDLE && cycle_start_i)
        begin
            shot_diag <= DIAG_RESET;
            shot_diag[EVT_BIT] <= event_flag_o;
            shot_diag[LOSS_BIT] <= comm_loss_flag_o;
            for (int p = 0; p < NPORT; p++)
            begin
                shot_stat[p][7:4] <= port_i[p].err;
                shot_stat[p][PDI_BIT] <= port_i[p].pd_invalid;
                shot_stat[p][2] <= 1'b0;
                shot_stat[p][1:0] <= port_i[p].mode;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next port with a non-empty data entry, NPORT if none
    function automatic logic [2:0] next_port(input logic [2:0] from,
                                             input logic [NPORT-1:0][5:0] len);
        logic [2:0] r;
        r = 3'(NPORT);
        for (int p = NPORT - 1; p >= 0; p--)
        begin
            if (3'(p) >= from && len[p] != '0)
                r = 3'(p);
        end
        return r;
    endfunction

    assign first_pd = next_port(3'h0, pd_len);
    assign after_pd = next_port(port_sel + 3'h1, pd_len);

    ////////////////////////////////////////////////////////////////////////////
    // Byte selection; data bytes pass untouched as an octet string
    always_comb
    begin
        push_data = '0;
        is_last = 1'b0;
        unique case (state)
            ST_IDLE:
            begin
                push_data = '0;
            end
            ST_DIAG:
            begin
                push_data.data = byte_cnt[0] ? shot_diag[15:8] : shot_diag[7:0];
                push_data.first = byte_cnt == '0;
            end
            ST_STAT:
            begin
                push_data.data = shot_stat[byte_cnt[1:0]];
                is_last = byte_cnt == 6'(STAT_BYTES - 1) && first_pd == 3'(NPORT);
            end
            ST_PD:
            begin
                push_data.data = pd_data_i;
                is_last = byte_cnt == pd_len[port_sel[1:0]] - 6'h1
                    && after_pd == 3'(NPORT);
            end
        endcase
        push_data.last = is_last;
    end

    assign push = state != ST_IDLE;
    assign busy_o = state != ST_IDLE;
    assign pd_port_o = port_sel[1:0];
    assign pd_index_o = byte_cnt[4:0];

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer: stalls while the FIFO is full
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state <= ST_IDLE;
            byte_cnt <= '0;
            port_sel <= '0;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                begin
                    byte_cnt <= '0;
                    port_sel <= '0;
                    if (cycle_start_i)
                        state <= ST_DIAG;
                end
                ST_DIAG:
                begin
                    if (fifo_ready)
                    begin
                        byte_cnt <= byte_cnt + 6'h1;
                        if (byte_cnt == 6'(DIAG_BYTES - 1))
                        begin
                            byte_cnt <= '0;
                            state <= ST_STAT;
                        end
                    end
                end
                ST_STAT:
                begin
                    if (fifo_ready)
                    begin
                        byte_cnt <= byte_cnt + 6'h1;
                        if (byte_cnt == 6'(STAT_BYTES - 1))
                        begin
                            byte_cnt <= '0;
                            port_sel <= first_pd;
                            state <= is_last ? ST_IDLE : ST_PD;
                        end
                    end
                end
                ST_PD:
                begin
                    if (fifo_ready)
                    begin
                        byte_cnt <= byte_cnt + 6'h1;
                        if (byte_cnt == pd_len[port_sel[1:0]] - 6'h1)
                        begin
                            byte_cnt <= '0;
                            port_sel <= after_pd;
                            if (is_last)
                                state <= ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    iolm_fifo #(
        .WIDTH(IMG_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .in_valid_i(push),
        .in_ready_o(fifo_ready),
        .in_data_i(push_data),
        .out_valid_o(img_valid_o),
        .out_ready_i(img_ready_i),
        .out_data_o(img_o)
    );
endmodule

// ---- pkg/iolm_pkg.sv ----
// Constants, codes and carriers of the sensor-link master input image
//
// Behaviour
// - Cyclic class carries process data and status; acyclic class is handled elsewhere.
// - By default the input image holds only the diagnostic and status entries.
// - A port's process data appears only after configuration and a reload.
// - Diagnostic entry is two bytes holding the event and comm-loss flags.
// - Status entry is four bytes, one status byte per port, in port order.
// - Each port's process data entry is zero to thirty-two bytes, as configured.
// - Process values of non-standard types pass as plain octet strings.
// - Event flag sets when any attached device reports an event.
// - Comm-loss flag sets when communication with any attached device is interrupted.
// - Status low nibble: 0 disabled, 1 digital in, 2 digital out, 3 operate.
// - Status bit value 8 flags invalid process data for that port.
// - Status high nibble: 1 watchdog, 2 internal error.
// - High nibble 3..7: device id, vendor id, version, frame, cycle-time mismatch.
// - High nibble 8 in length, 9 out length, A no device, B preop/storage.
package iolm_pkg;

    localparam int NPORT = 4;
    localparam int PD_MAX = 32;
    localparam int FIFO_DEPTH = 16;
    localparam int DIAG_BYTES = 2;
    localparam int STAT_BYTES = 4;

    // Positions inside the 16-bit diagnostic word, sent low byte first; PDI_BIT sits in the status byte
    localparam int EVT_BIT = 12;
    localparam int LOSS_BIT = 15;
    localparam int PDI_BIT = 3;

    localparam logic [15:0] DIAG_RESET = 16'h0000;
    localparam logic [5:0] CFG_LEN_RESET = 6'h00;

    // Port state codes, low nibble
    localparam logic [1:0] MODE_DISABLED = 2'h0;
    localparam logic [1:0] MODE_DIG_IN = 2'h1;
    localparam logic [1:0] MODE_DIG_OUT = 2'h2;
    localparam logic [1:0] MODE_OPERATE = 2'h3;

    // Error cause codes, high nibble
    localparam logic [3:0] ERR_NONE = 4'h0;
    localparam logic [3:0] ERR_WATCHDOG = 4'h1;
    localparam logic [3:0] ERR_INTERNAL = 4'h2;
    localparam logic [3:0] ERR_DEVICE_ID = 4'h3;
    localparam logic [3:0] ERR_VENDOR_ID = 4'h4;
    localparam logic [3:0] ERR_VERSION = 4'h5;
    localparam logic [3:0] ERR_FRAME_CAP = 4'h6;
    localparam logic [3:0] ERR_CYCLE_TIME = 4'h7;
    localparam logic [3:0] ERR_PD_IN_LEN = 4'h8;
    localparam logic [3:0] ERR_PD_OUT_LEN = 4'h9;
    localparam logic [3:0] ERR_NO_DEVICE = 4'ha;
    localparam logic [3:0] ERR_PREOP = 4'hb;

    typedef struct packed {
        logic [3:0] err;
        logic pd_invalid;
        logic [1:0] mode;
    } iolm_port_s;

    typedef struct packed {
        logic [7:0] data;
        logic first;
        logic last;
    } iolm_img_s;

    localparam int IMG_W = $bits(iolm_img_s);

endpackage

// ---- dv/iolm_status_image_props.sv ----
// Checker on the input image builder ports
`timescale 1ns/10ps

module iolm_status_image_props
    import iolm_pkg::*;
#(
    parameter int NUM_PORTS = 4
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // Build control
    input wire logic cycle_start_i,
    input wire logic busy_o,
    // Image stream
    input wire logic img_valid_o,
    input wire logic img_ready_i,
    input wire iolm_pkg::iolm_img_s img_o,
    // Flags
    input wire logic [NUM_PORTS-1:0] event_i,
    input wire logic event_ack_i,
    input wire logic event_flag_o,
    input wire logic [NUM_PORTS-1:0] comm_lost_i,
    input wire logic comm_loss_flag_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    ////////////////////////////////////////////////////////////////////////////
    sequence s_start;
        cycle_start_i && !busy_o;
    endsequence
    sequence s_build;
        busy_o [*6];
    endsequence

    // Six header bytes at least, one per cycle
    property p_start_busy;
        s_start |=> s_build;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("image build too short");
    property p_idle;
        !busy_o && !cycle_start_i |=> !busy_o;
    endproperty
    a_idle: assert property (p_idle) else $error("build without start");
    property p_valid;
        s_start ##1 busy_o |=> img_valid_o;
    endproperty
    a_valid: assert property (p_valid) else $error("no image byte offered");
    property p_hold;
        img_valid_o && !img_ready_i |=> img_valid_o && $stable(img_o);
    endproperty
    a_hold: assert property (p_hold) else $error("image byte dropped");
    property p_first;
        img_valid_o && img_o.first |-> img_o.data == 8'h00;
    endproperty
    a_first: assert property (p_first) else $error("diag low byte not zero");
    property p_loss;
        $past(reset_n_i) |-> comm_loss_flag_o == (|$past(comm_lost_i));
    endproperty
    a_loss: assert property (p_loss) else $error("comm loss flag wrong");
    property p_evt_set;
        |event_i |=> event_flag_o;
    endproperty
    a_evt_set: assert property (p_evt_set) else $error("event flag not set");
    property p_evt_keep;
        event_flag_o && !event_ack_i |=> event_flag_o;
    endproperty
    a_evt_keep: assert property (p_evt_keep) else $error("event flag lost");
    property p_evt_clr;
        event_ack_i && !(|event_i) |=> !event_flag_o;
    endproperty
    a_evt_clr: assert property (p_evt_clr) else $error("event flag not cleared");
endmodule

// ---- dv/iolm_reader.sv ----
// Controller-side reader of the image stream
`timescale 1ns/10ps

module iolm_reader
    import iolm_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // Stream
    input wire logic slow_i,
    input wire logic img_valid_i,
    input wire iolm_pkg::iolm_img_s img_i,
    output logic img_ready_o
);
    iolm_img_s got[$];
    logic [1:0] phase;

    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            phase <= 2'h0;
        else
            phase <= phase + 2'h1;
    end
    // Slow mode takes one beat in four so the buffer fills
    assign img_ready_o = !slow_i || (phase == 2'h3);
    // Cyclic bytes only; acyclic parameter access by index never uses this stream
    always @(posedge clock_i)
    begin
        if (reset_n_i && img_valid_i && img_ready_o)
            got.push_back(img_i);
    end
endmodule

// ---- dv/iolm_status_image_tb.sv ----
// Testbench of the input image builder
`timescale 1ns/10ps

module iolm_status_image_tb
    import iolm_pkg::*;
;
    logic clock_i, reset_n_i, cycle_start_i, reload_i, event_ack_i, img_ready_i;
    logic busy_o, img_valid_o, event_flag_o, comm_loss_flag_o, slow, exp_evt, exp_loss;
    logic [3:0] cfg_used_i, event_i, comm_lost_i;
    logic [3:0][5:0] cfg_len_i;
    iolm_port_s [3:0] port_i;
    logic [1:0] pd_port_o;
    logic [4:0] pd_index_o;
    logic [7:0] pd_data_i;
    iolm_img_s img_o;
    int bad_count, total_checks, cycles, i, k;
    int lens[4];

    assign pd_data_i = {pd_port_o, 1'b0, pd_index_o};
    iolm_status_image iolm_status_image_inst (.clock_i, .reset_n_i, .cycle_start_i,
        .reload_i, .cfg_used_i, .cfg_len_i, .busy_o, .port_i, .event_i, .comm_lost_i,
        .event_ack_i, .pd_port_o, .pd_index_o, .pd_data_i, .img_valid_o, .img_ready_i,
        .img_o, .event_flag_o, .comm_loss_flag_o);
    iolm_reader iolm_reader_inst (.clock_i, .reset_n_i, .slow_i(slow),
        .img_valid_i(img_valid_o), .img_i(img_o), .img_ready_o(img_ready_i));

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic compare_img(string what, iolm_img_s exp, iolm_img_s got);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic compare_bit(string what, logic exp, logic got);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected %s expected %b seen %b", what, exp, got);
        end
    endtask
    // Builds the expected image, starts it twice (second start lands mid-build)
    task automatic run_image(string name);
        iolm_img_s exp[$];
        int n, p;
        exp.push_back('{8'h00, 1'b1, 1'b0});
        exp.push_back('{{exp_loss, 2'h0, exp_evt, 4'h0}, 1'b0, 1'b0});
        for (p = 0; p < 4; p++)
            exp.push_back('{{port_i[p].err, port_i[p].pd_invalid, 1'b0, port_i[p].mode},
                1'b0, 1'b0});
        for (p = 0; p < 4; p++)
            for (n = 0; n < lens[p]; n++)
                exp.push_back('{{p[1:0], 1'b0, n[4:0]}, 1'b0, 1'b0});
        exp[$].last = 1'b1;
        iolm_reader_inst.got = {};
        @(posedge clock_i) #1 cycle_start_i = 1'b1;
        @(posedge clock_i) #1 cycle_start_i = 1'b0;
        repeat (2) @(posedge clock_i);
        #1 cycle_start_i = 1'b1;
        @(posedge clock_i) #1 cycle_start_i = 1'b0;
        for (n = 0; n < 2000 && iolm_reader_inst.got.size() < exp.size(); n++)
            @(posedge clock_i);
        repeat (20) @(posedge clock_i);
        // Leave the edge so the caller's next stimulus never races the design
        #1;
        compare_bit("image size", 1'b1, iolm_reader_inst.got.size() == exp.size());
        for (n = 0; n < exp.size(); n++)
            compare_img("image byte", exp[n], iolm_reader_inst.got[n]);
        $display("test %s done", name);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {cycle_start_i, reload_i, event_ack_i, slow, exp_evt, exp_loss} = 6'h00;
        {event_i, comm_lost_i, port_i} = '0;
        cfg_used_i = 4'hf;
        cfg_len_i = {4{6'h05}};
        lens = '{0, 0, 0, 0};
        reset_n_i = 1'b0;
        repeat (20) @(posedge clock_i);
        #1 reset_n_i = 1'b1;
        run_image("default image");
        for (i = 0; i < 3; i++)
        begin
            for (k = 0; k < 4; k++)
                port_i[k] = {4'(i * 4 + k), 1'(i + k), 2'(k)};
            comm_lost_i = (i == 1) ? 4'h4 : 4'h0;
            event_i = (i == 2) ? 4'h8 : 4'h0;
            {exp_loss, exp_evt} = {i == 1, i == 2};
            @(posedge clock_i) #1 event_i = 4'h0;
            run_image("status codes");
        end
        // Event arriving with the ack wins; a lone ack clears
        event_i = 4'h1;
        event_ack_i = 1'b1;
        @(posedge clock_i) #1 event_i = 4'h0;
        compare_bit("event flag", 1'b1, event_flag_o);
        @(posedge clock_i) #1 event_ack_i = 1'b0;
        compare_bit("event flag", 1'b0, event_flag_o);
        exp_evt = 1'b0;
        cfg_used_i = 4'he;
        cfg_len_i = {6'h28, 6'h20, 6'h01, 6'h07};
        reload_i = 1'b1;
        @(posedge clock_i) #1 reload_i = 1'b0;
        lens = '{0, 1, 32, 32};
        slow = 1'b1;
        run_image("configured data");
        // Reset mid-run drops the sticky flag and the configured lengths
        event_i = 4'h2;
        @(posedge clock_i) #1 event_i = 4'h0;
        reset_n_i = 1'b0;
        @(posedge clock_i) #1 reset_n_i = 1'b1;
        compare_bit("event flag", 1'b0, event_flag_o);
        compare_bit("image valid", 1'b0, img_valid_o);
        lens = '{0, 0, 0, 0};
        run_image("image after reset");
        end_of_test();
    end
endmodule

bind iolm_status_image iolm_status_image_props #(.NUM_PORTS(NUM_PORTS))
    iolm_status_image_props_inst (.clock_i, .reset_n_i, .cycle_start_i, .busy_o,
    .img_valid_o, .img_ready_i, .img_o, .event_i, .event_ack_i, .event_flag_o,
    .comm_lost_i, .comm_loss_flag_o);
